// File: logic/psrb_regs.sv
// Register bank of the pressure sensor: command, results, status, serial number
`timescale 1ns/1ns
`default_nettype none
module psrb_regs
  import psrb_pkg::*;
#(
  parameter logic [15:0] RESET_CODE = CMD_RESET_DEFAULT,
  parameter int CFG_AW = 2
)(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic frame_start_in,
  input wire logic [7:0] addr_byte_in,
  input wire logic wr_valid_in,
  input wire logic [7:0] wr_byte_in,
  input wire logic rd_req_in,
  output logic [7:0] rd_byte_out,
  output logic rd_valid_out,
  input wire logic com_crc_error_in,
  input wire logic busy_in,
  input wire logic dsp_sat_in,
  input wire logic bridge_supply_failure_in,
  input wire logic bridge_check_failure_in,
  input wire logic temp_load_in,
  input wire logic [15:0] temp_value_in,
  input wire logic press_load_in,
  input wire logic [15:0] press_value_in,
  input wire logic cfg_wr_en_in,
  input wire logic [CFG_AW-1:0] cfg_wr_addr_in,
  input wire logic [15:0] cfg_wr_data_in,
  output logic sleep_out,
  output logic powerup_busy_out,
  output logic cfg_crc_ok_out
);
  // CRC-8 over one 16-bit word, high bit first
  function automatic logic [7:0] crc8_word(input logic [7:0] crc, input logic [15:0] data);
    logic [7:0] c;
    c = crc;
    for (int i = 15; i >= 0; i--)
    begin
      if (c[7] ^ data[i])
      begin
        c = {c[6:0], 1'b0} ^ CRC_POLY;
      end
      else
      begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction

  localparam logic [CFG_AW-1:0] CFG_LAST = CFG_AW'(CFG_DEPTH - 1);

  psrb_state_t state_r;
  logic [7:0] ptr_r;
  logic [15:0] temp_r;
  logic [15:0] press_r;
  logic [15:0] events_r;
  logic [1:0] sync_up_r;
  logic [15:0] ser_low_r;
  logic [15:0] ser_high_r;
  logic [7:0] crc_r;
  logic [CFG_AW-1:0] cfg_addr_r;
  logic cfg_pend_r;
  logic [CFG_AW-1:0] cfg_idx_r;
  logic [15:0] cfg_data;
  logic sleep_r;
  logic pu_busy_r;
  logic crc_ok_r;

  logic word_wr;
  logic [15:0] word_data;
  logic word_rd;
  logic advance;
  logic [7:0] wr_addr_r;
  logic [15:0] live_status;
  logic [15:0] sync_status;
  logic [15:0] rd_word;
  logic status_wr;
  logic cmd_wr;
  logic temp_rd;
  logic press_rd;
  logic temp_upd;
  logic press_upd;
  logic [15:0] ev_set;
  logic [15:0] ev_clr;

  psrb_byte_pair u_pair (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .frame_start_in(frame_start_in),
    .wr_valid_in(wr_valid_in),
    .wr_byte_in(wr_byte_in),
    .rd_req_in(rd_req_in),
    .rd_word_in(rd_word),
    .word_wr_out(word_wr),
    .word_out(word_data),
    .word_rd_out(word_rd),
    .advance_out(advance),
    .rd_byte_out(rd_byte_out),
    .rd_valid_out(rd_valid_out)
  );

  psrb_cfg_mem #(
    .DEPTH(CFG_DEPTH),
    .WIDTH(16),
    .AW(CFG_AW)
  ) u_cfg (
    .clk_in(clk_in),
    .wr_en_in(cfg_wr_en_in),
    .wr_addr_in(cfg_wr_addr_in),
    .wr_data_in(cfg_wr_data_in),
    .rd_addr_in(cfg_addr_r),
    .rd_data_out(cfg_data)
  );

  // Word pointer: loaded by the address byte, stepped after each high byte
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      ptr_r <= 8'h00;
      wr_addr_r <= 8'h00;
    end
    else if (frame_start_in)
    begin
      ptr_r <= addr_byte_in;
    end
    else if (advance)
    begin
      ptr_r <= ptr_r + ADDR_STEP;
      wr_addr_r <= ptr_r; // Word write lands one cycle later
    end
  end

  // Write and read decode; every other address is write protected
  assign status_wr = word_wr && (wr_addr_r == ADDR_LIVE_STATUS);
  assign cmd_wr = word_wr && (wr_addr_r == ADDR_COMMAND);
  assign temp_rd = word_rd && (ptr_r == ADDR_TEMP);
  assign press_rd = word_rd && (ptr_r == ADDR_PRESS);

  // Results only move once the configuration passed its check
  assign temp_upd = temp_load_in && crc_ok_r && (state_r == PSRB_RUN) && !sleep_r;
  assign press_upd = press_load_in && crc_ok_r && (state_r == PSRB_RUN) && !sleep_r;

  // Power-up sequence: read every configuration word, check, then run
  always_ff @(posedge clk_in)
  begin
    if (rst_in || (cmd_wr && word_data == RESET_CODE))
    begin
      state_r <= PSRB_LOAD;
      cfg_addr_r <= '0;
      cfg_idx_r <= '0;
      cfg_pend_r <= 1'b0;
      crc_r <= CRC_INIT;
      crc_ok_r <= 1'b0;
      pu_busy_r <= 1'b1;
      ser_low_r <= 16'h0000;
      ser_high_r <= 16'h0000;
    end
    else
    begin
      unique case (state_r)
        PSRB_LOAD:
        begin
          cfg_pend_r <= 1'b1;
          cfg_idx_r <= cfg_addr_r;
          if (cfg_addr_r != CFG_LAST)
          begin
            cfg_addr_r <= cfg_addr_r + 1'b1;
          end
          if (cfg_pend_r)
          begin
            if (cfg_idx_r == CFG_AW'(CFG_SER_LOW_IDX))
            begin
              ser_low_r <= cfg_data;
            end
            if (cfg_idx_r == CFG_AW'(CFG_SER_HIGH_IDX))
            begin
              ser_high_r <= cfg_data;
            end
            if (cfg_idx_r == CFG_LAST)
            begin
              crc_ok_r <= (cfg_data[7:0] == crc_r);
              state_r <= PSRB_CHECK;
            end
            else
            begin
              crc_r <= crc8_word(crc_r, cfg_data);
            end
          end
        end
        PSRB_CHECK:
        begin
          pu_busy_r <= 1'b0;
          state_r <= PSRB_RUN;
        end
        PSRB_RUN:
        begin
          state_r <= PSRB_RUN;
        end
        default:
        begin
          state_r <= PSRB_LOAD;
        end
      endcase
    end
  end

  // Sleep follows the command word; a reset command wakes the device
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      sleep_r <= 1'b0;
    end
    else if (cmd_wr)
    begin
      sleep_r <= (word_data == CMD_SLEEP);
    end
  end

  // Result registers; no reset value is meaningful before the first load
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      temp_r <= RESULT_RESET;
      press_r <= RESULT_RESET;
    end
    else
    begin
      if (temp_upd)
      begin
        temp_r <= temp_value_in;
      end
      if (press_upd)
      begin
        press_r <= press_value_in;
      end
    end
  end

  // Event sources of this cycle
  always_comb
  begin
    ev_set = 16'h0000;
    ev_set[BIT_TEMP_UP] = temp_upd;
    ev_set[BIT_PRESS_UP] = press_upd;
    ev_set[BIT_TEMP_MISSED] = temp_upd && events_r[BIT_TEMP_UP];
    ev_set[BIT_PRESS_MISSED] = press_upd && events_r[BIT_PRESS_UP];
    ev_set[BIT_BRIDGE_SUPPLY] = bridge_supply_failure_in;
    ev_set[BIT_BRIDGE_CHECK] = bridge_check_failure_in;
    ev_set[BIT_COM_CRC] = com_crc_error_in;
  end

  // Event clears: write-one at the live address, or a result read
  always_comb
  begin
    ev_clr = 16'h0000;
    if (status_wr)
    begin
      ev_clr = word_data & EVENT_MASK;
    end
    ev_clr[BIT_TEMP_UP] = ev_clr[BIT_TEMP_UP] | temp_rd;
    ev_clr[BIT_PRESS_UP] = ev_clr[BIT_PRESS_UP] | press_rd;
  end

  // Sticky events; a set in the clearing cycle wins so no event is lost
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      events_r <= STATUS_RESET;
    end
    else
    begin
      events_r <= ((events_r & ~ev_clr) | ev_set) & EVENT_MASK;
    end
  end

  // Snapshot of the updated flags taken with the result read
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      sync_up_r <= 2'b00;
    end
    else
    begin
      if (temp_rd)
      begin
        sync_up_r[1] <= events_r[BIT_TEMP_UP];
      end
      if (press_rd)
      begin
        sync_up_r[0] <= events_r[BIT_PRESS_UP];
      end
    end
  end

  // Live view: events plus conditions that come and go by themselves
  always_comb
  begin
    live_status = events_r;
    live_status[BIT_IDLE] = !busy_in && !pu_busy_r;
    live_status[BIT_SAT] = dsp_sat_in;
  end

  // Synchronised view shares everything but the two updated flags
  always_comb
  begin
    sync_status = live_status;
    sync_status[BIT_TEMP_UP] = sync_up_r[1];
    sync_status[BIT_PRESS_UP] = sync_up_r[0];
  end

  // Read mux; the command word is write-only and reads as zero
  always_comb
  begin
    unique case (ptr_r)
      ADDR_TEMP: rd_word = temp_r;
      ADDR_PRESS: rd_word = press_r;
      ADDR_SYNC_STATUS: rd_word = sync_status;
      ADDR_LIVE_STATUS: rd_word = live_status;
      ADDR_SERIAL_LOW: rd_word = ser_low_r;
      ADDR_SERIAL_HIGH: rd_word = ser_high_r;
      default: rd_word = 16'h0000;
    endcase
  end

  // Control outputs come straight from their registers
  assign sleep_out = sleep_r;
  assign powerup_busy_out = pu_busy_r;
  assign cfg_crc_ok_out = crc_ok_r;
endmodule
`default_nettype wire

// File: logic/psrb_pkg.sv
// Package of register map, field positions and constants of the pressure sensor register bank
package psrb_pkg;
  // Register addresses (byte addresses of 16-bit words)
  localparam logic [7:0] ADDR_COMMAND = 8'h22;
  localparam logic [7:0] ADDR_TEMP = 8'h2E;
  localparam logic [7:0] ADDR_PRESS = 8'h30;
  localparam logic [7:0] ADDR_SYNC_STATUS = 8'h32;
  localparam logic [7:0] ADDR_LIVE_STATUS = 8'h36;
  localparam logic [7:0] ADDR_SERIAL_LOW = 8'h50;
  localparam logic [7:0] ADDR_SERIAL_HIGH = 8'h52;
  localparam logic [7:0] ADDR_STEP = 8'h02;
  // Command codes
  localparam logic [15:0] CMD_SLEEP = 16'h6C32;
  localparam logic [15:0] CMD_RESET_DEFAULT = 16'h5A5A;
  // Status field positions
  localparam int BIT_IDLE = 0;
  localparam int BIT_PRESS_UP = 3;
  localparam int BIT_TEMP_UP = 4;
  localparam int BIT_BRIDGE_SUPPLY = 7;
  localparam int BIT_BRIDGE_CHECK = 8;
  localparam int BIT_SAT = 10;
  localparam int BIT_COM_CRC = 11;
  localparam int BIT_PRESS_MISSED = 14;
  localparam int BIT_TEMP_MISSED = 15;
  // Event bits: 3, 4, 7, 8, 11, 14, 15
  localparam logic [15:0] EVENT_MASK = 16'hC998;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  // Configuration memory layout: serial words, spare, check byte in last word
  localparam int CFG_DEPTH = 4;
  localparam int CFG_SER_LOW_IDX = 0;
  localparam int CFG_SER_HIGH_IDX = 1;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  // Power-up sequencer states
  typedef enum logic [1:0] {
    PSRB_LOAD = 2'b00,
    PSRB_CHECK = 2'b01,
    PSRB_RUN = 2'b10
  } psrb_state_t;
endpackage

// File: logic/psrb_cfg_mem.sv
// Small configuration memory with a write port and a registered read port
`timescale 1ns/1ns
`default_nettype none
module psrb_cfg_mem
  import psrb_pkg::*;
#(
  parameter int DEPTH = 4,
  parameter int WIDTH = 16,
  parameter int AW = 2
)(
  input wire logic clk_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [WIDTH-1:0] rd_data_out
);
  logic [WIDTH-1:0] mem_r [DEPTH];

  // Write port; contents survive the register reset on purpose
  always_ff @(posedge clk_in)
  begin
    if (wr_en_in)
    begin
      mem_r[wr_addr_in] <= wr_data_in;
    end
  end

  // Registered read, one cycle of latency
  always_ff @(posedge clk_in)
  begin
    rd_data_out <= mem_r[rd_addr_in];
  end
endmodule
`default_nettype wire

// File: logic/psrb_byte_pair.sv
// Pairs serial bytes into 16-bit words, low byte first, in both directions
`timescale 1ns/1ns
`default_nettype none
module psrb_byte_pair
  import psrb_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic frame_start_in,
  input wire logic wr_valid_in,
  input wire logic [7:0] wr_byte_in,
  input wire logic rd_req_in,
  input wire logic [15:0] rd_word_in,
  output logic word_wr_out,
  output logic [15:0] word_out,
  output logic word_rd_out,
  output logic advance_out,
  output logic [7:0] rd_byte_out,
  output logic rd_valid_out
);
  logic hi_phase_r;
  logic [7:0] lo_byte_r;
  logic [7:0] rd_hi_r;

  // The word is fetched on the low byte, so both halves come from one snapshot
  assign word_rd_out = rd_req_in & ~hi_phase_r;
  assign advance_out = (rd_req_in | wr_valid_in) & hi_phase_r;

  // Byte phase; a new frame always restarts on a low byte
  always_ff @(posedge clk_in)
  begin
    if (rst_in || frame_start_in)
    begin
      hi_phase_r <= 1'b0;
    end
    else if (rd_req_in || wr_valid_in)
    begin
      hi_phase_r <= ~hi_phase_r;
    end
  end

  // Write assembly: low byte held, word emitted with the high byte
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      lo_byte_r <= 8'h00;
      word_wr_out <= 1'b0;
      word_out <= 16'h0000;
    end
    else
    begin
      word_wr_out <= wr_valid_in & hi_phase_r & ~frame_start_in;
      if (wr_valid_in && !hi_phase_r)
      begin
        lo_byte_r <= wr_byte_in;
      end
      if (wr_valid_in && hi_phase_r)
      begin
        word_out <= {wr_byte_in, lo_byte_r};
      end
    end
  end

  // Read split: low byte now, high byte kept for the next request
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      rd_hi_r <= 8'h00;
      rd_byte_out <= 8'h00;
      rd_valid_out <= 1'b0;
    end
    else
    begin
      rd_valid_out <= rd_req_in;
      if (word_rd_out)
      begin
        rd_byte_out <= rd_word_in[7:0];
        rd_hi_r <= rd_word_in[15:8];
      end
      else if (rd_req_in)
      begin
        rd_byte_out <= rd_hi_r;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/psrb_host.sv
// Host model: bus master on the byte port of the register bank
`timescale 1ns/1ns
`default_nettype none
module psrb_host(
  input wire logic clk_in,
  input wire logic [7:0] rd_byte_in,
  input wire logic rd_valid_in,
  output logic frame_start_out,
  output logic [7:0] addr_byte_out,
  output logic wr_valid_out,
  output logic [7:0] wr_byte_out,
  output logic rd_req_out
);
  // Idle at time zero; released lines carry the inverse of their last value
  initial
  begin
    frame_start_out = 1'b0;
    addr_byte_out = 8'h00;
    wr_valid_out = 1'b0;
    wr_byte_out = 8'h00;
    rd_req_out = 1'b0;
  end
  // Address phase
  task automatic start(input logic [7:0] a);
    @(negedge clk_in);
    frame_start_out = 1'b1;
    addr_byte_out = a;
    @(negedge clk_in);
    frame_start_out = 1'b0;
    addr_byte_out = ~a;
  endtask
  // One word, low byte first
  task automatic wr_word(input logic [7:0] a, input logic [15:0] w);
    start(a);
    wr_valid_out = 1'b1;
    wr_byte_out = w[7:0];
    @(negedge clk_in);
    wr_byte_out = w[15:8];
    @(negedge clk_in);
    wr_valid_out = 1'b0;
    wr_byte_out = ~w[15:8];
  endtask
  // Burst of n words; a byte without its valid pulse reads as unknown
  task automatic rd_burst(input logic [7:0] a, input int n, output logic [47:0] q);
    q = '0;
    start(a);
    rd_req_out = 1'b1;
    for (int i = 0; i < 2 * n; i++)
    begin
      @(negedge clk_in);
      if (i == 2 * n - 1)
        rd_req_out = 1'b0;
      q[8*i+:8] = rd_valid_in ? rd_byte_in : 8'hxx;
    end
  endtask
endmodule
`default_nettype wire

// File: tb/psrb_regs_chk.sv
// Port checker of the register bank
`timescale 1ns/1ns
`default_nettype none
module psrb_regs_chk(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wr_valid_in,
  input wire logic rd_req_in,
  input wire logic [7:0] rd_byte_out,
  input wire logic rd_valid_out,
  input wire logic sleep_out,
  input wire logic powerup_busy_out,
  input wire logic cfg_crc_ok_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Power-up load must finish in bounded time after release
  sequence s_release;
    $fell(rst_in);
  endsequence
  // State changes only follow a written word
  sequence s_recent_write;
    $past(wr_valid_in, 1) || $past(wr_valid_in, 2) || $past(wr_valid_in, 3);
  endsequence
  a_read_answer: assert property (rd_req_in |=> rd_valid_out)
    else $error("read request without answer");
  a_no_extra_valid: assert property (!rd_req_in |=> !rd_valid_out)
    else $error("read valid without request");
  a_byte_stands: assert property (!rd_req_in |=> $stable(rd_byte_out))
    else $error("read byte moved without request");
  a_reset_values: assert property (disable iff (1'b0) rst_in |=>
    (powerup_busy_out && !sleep_out && !cfg_crc_ok_out && !rd_valid_out))
    else $error("outputs not at reset values");
  a_load_bounded: assert property (s_release |-> ##[1:10] !powerup_busy_out)
    else $error("power-up load did not finish");
  a_reload_bounded: assert property ($rose(powerup_busy_out) |-> ##[1:10] !powerup_busy_out)
    else $error("reload did not finish");
  a_reload_cause: assert property ($rose(powerup_busy_out) |-> s_recent_write)
    else $error("reload without command");
  a_sleep_cause: assert property ($rose(sleep_out) |-> s_recent_write)
    else $error("sleep without command");
  a_wake_cause: assert property ($fell(sleep_out) |-> s_recent_write)
    else $error("wake without command");
endmodule
bind psrb_regs psrb_regs_chk u_chk(
  .clk_in(clk_in),
  .rst_in(rst_in),
  .wr_valid_in(wr_valid_in),
  .rd_req_in(rd_req_in),
  .rd_byte_out(rd_byte_out),
  .rd_valid_out(rd_valid_out),
  .sleep_out(sleep_out),
  .powerup_busy_out(powerup_busy_out),
  .cfg_crc_ok_out(cfg_crc_ok_out)
);
`default_nettype wire

// File: tb/tb_psrb_regs.sv
// Self-checking bench of the pressure sensor register bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin fail_count++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_psrb_regs
  import psrb_pkg::*;
;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic fs, wv, rq, rv, slp, pbusy, crc_ok, ld_t, ld_p, cfg_en;
  logic crc_err = 1'b0, busy = 1'b0, sat = 1'b0, supply_fail = 1'b0, check_fail = 1'b0;
  logic [7:0] ab, wb, rb;
  logic [15:0] t_val, p_val, cfg_d;
  logic [1:0] cfg_a;
  logic [47:0] q;
  int fail_count = 0;
  int checks = 0;
  always #4 clk_in = ~clk_in;
  psrb_host u_host(.clk_in(clk_in), .rd_byte_in(rb), .rd_valid_in(rv), .frame_start_out(fs),
    .addr_byte_out(ab), .wr_valid_out(wv), .wr_byte_out(wb), .rd_req_out(rq));
  psrb_regs DUT(.clk_in(clk_in), .rst_in(rst_in), .frame_start_in(fs), .addr_byte_in(ab),
    .wr_valid_in(wv), .wr_byte_in(wb), .rd_req_in(rq), .rd_byte_out(rb), .rd_valid_out(rv),
    .com_crc_error_in(crc_err), .busy_in(busy), .dsp_sat_in(sat),
    .bridge_supply_failure_in(supply_fail), .bridge_check_failure_in(check_fail),
    .temp_load_in(ld_t), .temp_value_in(t_val), .press_load_in(ld_p), .press_value_in(p_val),
    .cfg_wr_en_in(cfg_en), .cfg_wr_addr_in(cfg_a), .cfg_wr_data_in(cfg_d), .sleep_out(slp),
    .powerup_busy_out(pbusy), .cfg_crc_ok_out(crc_ok));
  task automatic print_verdict();
    if (fail_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic expect_reg(input string nm, input logic [7:0] a, input logic [15:0] ex);
    logic [47:0] r;
    u_host.rd_burst(a, 1, r);
    `CHK(nm, ex, r[15:0])
  endtask
  // Write effects land two cycles after the high byte
  task automatic settle();
    repeat (3) @(negedge clk_in);
  endtask
  task automatic wait_load();
    int n;
    n = 0;
    while (pbusy !== 1'b0 && n < 40)
    begin
      @(negedge clk_in);
      n++;
    end
    if (n == 40)
    begin
      fail_count++;
      print_verdict();
    end
  endtask
  task automatic load(input logic is_t, input logic [15:0] v);
    @(negedge clk_in);
    ld_t = is_t;
    ld_p = !is_t;
    t_val = v;
    p_val = v;
    @(negedge clk_in);
    ld_t = 1'b0;
    ld_p = 1'b0;
  endtask
  task automatic cfg_word(input logic [1:0] a, input logic [15:0] d);
    @(negedge clk_in);
    cfg_en = 1'b1;
    cfg_a = a;
    cfg_d = d;
    @(negedge clk_in);
    cfg_en = 1'b0;
  endtask
  // Bad check byte: results frozen, protected register keeps contents
  task automatic t_crc_fail();
    wait_load();
    `CHK("crc_ok", 1'b0, crc_ok)
    load(1'b1, 16'h7DF2);
    expect_reg("temp_frozen", ADDR_TEMP, RESULT_RESET);
    expect_reg("idle", ADDR_LIVE_STATUS, 16'h0001);
    u_host.wr_word(ADDR_TEMP, 16'hBEEF);
    settle();
    expect_reg("temp_prot", ADDR_TEMP, RESULT_RESET);
  endtask
  // New serial words with their matching check byte, so the reload must pass
  task automatic t_reset_cmd();
    cfg_word(2'd0, 16'h0001);
    cfg_word(2'd1, 16'h0100);
    cfg_word(2'd3, 16'h0074);
    u_host.wr_word(ADDR_COMMAND, CMD_RESET_DEFAULT);
    settle();
    wait_load();
    `CHK("crc_ok", 1'b1, crc_ok)
    expect_reg("ser_lo", ADDR_SERIAL_LOW, 16'h0001);
    expect_reg("ser_hi", ADDR_SERIAL_HIGH, 16'h0100);
  endtask
  // Double loads, flags polled before results are used
  task automatic t_updates();
    load(1'b1, 16'h7DF2);
    load(1'b0, 16'h82EA);
    load(1'b0, 16'h0F0F);
    load(1'b1, 16'h1E00);
    expect_reg("flags", ADDR_LIVE_STATUS, 16'hC019);
    u_host.rd_burst(ADDR_TEMP, 3, q);
    `CHK("burst", 48'hC019_0F0F_1E00, q)
    expect_reg("rd_clear", ADDR_LIVE_STATUS, 16'hC001);
  endtask
  task automatic t_events();
    @(negedge clk_in);
    crc_err = 1'b1;
    supply_fail = 1'b1;
    check_fail = 1'b1;
    sat = 1'b1;
    @(negedge clk_in);
    crc_err = 1'b0;
    supply_fail = 1'b0;
    check_fail = 1'b0;
    expect_reg("events", ADDR_LIVE_STATUS, 16'hCD81);
    u_host.wr_word(ADDR_SYNC_STATUS, 16'hFFFF);
    settle();
    expect_reg("sync_wr", ADDR_LIVE_STATUS, 16'hCD81);
    u_host.wr_word(ADDR_LIVE_STATUS, 16'h0080);
    settle();
    expect_reg("clr_one", ADDR_LIVE_STATUS, 16'hCD01);
    sat = 1'b0;
    expect_reg("sat_off", ADDR_LIVE_STATUS, 16'hC901);
    u_host.wr_word(ADDR_LIVE_STATUS, 16'hFFFF);
    settle();
    expect_reg("clr_all", ADDR_LIVE_STATUS, 16'h0001);
    busy = 1'b1;
    expect_reg("busy", ADDR_LIVE_STATUS, 16'h0000);
    busy = 1'b0;
  endtask
  // Asleep: no result updates, command reads zero
  task automatic t_sleep();
    u_host.wr_word(ADDR_COMMAND, CMD_SLEEP);
    settle();
    `CHK("sleep", 1'b1, slp)
    expect_reg("cmd_wo", ADDR_COMMAND, 16'h0000);
    load(1'b1, 16'h5555);
    expect_reg("asleep", ADDR_TEMP, 16'h1E00);
    u_host.wr_word(ADDR_COMMAND, 16'h0000);
    settle();
    `CHK("wake", 1'b0, slp)
  endtask
  // Memory is programmed inside the 12 reset cycles, check byte wrong on purpose
  initial
  begin
    {ld_t, ld_p, cfg_en, cfg_a, t_val, p_val, cfg_d} = '0;
    cfg_word(2'd0, 16'h0000);
    cfg_word(2'd1, 16'h0000);
    cfg_word(2'd2, 16'h0000);
    cfg_word(2'd3, 16'h00A5);
    repeat (4) @(negedge clk_in);
    rst_in = 1'b0;
    t_crc_fail();
    t_reset_cmd();
    t_updates();
    t_events();
    t_sleep();
    print_verdict();
  end
endmodule
`default_nettype wire
